// ---- cfb_filter_window.v ----
// Host-side register logic of a CAN controller: identifier filter registers,
// a four-stage receive window and three transmit buffers behind one window.
// Assumes a byte-wide host port on mclk and a protocol engine on the same clock.
//
// Contract
// - Acceptance filter registers reset to zero.
// - Mask filter registers reset to zero.
// - Filters always readable; writes only when init request and acknowledge both one.
// - Received frames queue in a four-stage FIFO, shown one entry at a time.
// - Every receive and transmit buffer carries its own timestamp bytes.
// - Receive window decoded at offset 0x20.
// - Receive window reads valid only while receive-full set; host writes ignored.
// - Exactly three transmit buffers.
// - Only one transmit buffer mapped at a time through the shared window.
// - Transmit window decoded at offset 0x30.
// - Lowest set select bit wins; only that bit reads back as one.
// - No select bit set: window writes dropped, reads return zero.
// - Selected buffer reachable only while its empty flag is set.
// - Timestamp bytes are read-only to the host.
`timescale 1ns/10ps
`include "cfb_defines.vh"

module cfb_filter_window (
    // Clock and reset
    input wire mclk,
    input wire reset_n,
    // Host register port
    input wire [5:0] cpuAddr,
    input wire cpuRead,
    input wire cpuWrite,
    input wire [7:0] cpuWdata,
    output reg [7:0] cpuRdata,
    // Mode bits
    input wire initRequest,
    input wire initAcknowledge,
    // Receive path from the protocol engine
    input wire rxFrameValid,
    input wire [127:0] rxFrameData,
    output wire rxFrameReady,
    // Receive status and release
    input wire rxRelease,
    output wire receiveFullFlag,
    // Transmit buffer hand-off
    input wire [2:0] txLaunch,
    input wire [2:0] txDone,
    input wire [2:0] txStampWrite,
    input wire [15:0] txStamp,
    output reg [2:0] txEmptyFlag,
    output reg [2:0] txSelectView,
    // Protocol engine read port into transmit buffers
    input wire [1:0] txEngBuffer,
    input wire [3:0] txEngIndex,
    output reg [7:0] txEngData
);
    reg [7:0] filt [0:`CFB_FILT_REGS-1];
    reg [7:0] txMem [0:`CFB_TX_BYTES-1];
    reg [2:0] txBufferSelect;
    reg [7:0] next_rdata;
    reg [1:0] selIdx;
    wire [127:0] rxHead;
    wire [1:0] win = cpuAddr[5:4];
    wire [3:0] idx = cpuAddr[3:0];
    wire initMode = initRequest && initAcknowledge;
    wire runMode = !initRequest && !initAcknowledge;
    wire [2:0] selLow = txBufferSelect & (~txBufferSelect + 3'h1);
    wire selAny = |selLow;
    wire selOk = selAny && txEmptyFlag[selIdx];
    wire isStamp = (idx == `CFB_TS_HI) || (idx == `CFB_TS_LO);
    wire [5:0] txWinAddr = {selIdx, idx};
    wire [5:0] txEngAddr = {txEngBuffer, txEngIndex};

    // Window decode, one hit per host-visible region
    wire filtHit = (win == `CFB_WIN_FILT);
    wire rxHit = (win == `CFB_WIN_RX);
    wire txHit = (win == `CFB_WIN_TX);
    wire selHit = (cpuAddr == `CFB_OFS_TBSEL);

    // Write qualifiers; a write that misses all of them is dropped silently
    wire filtWriteOk = cpuWrite && filtHit && initMode;
    wire selWriteOk = cpuWrite && selHit && runMode;
    // Stamp bytes belong to the engine, so the host can never corrupt them
    wire txWriteOk = cpuWrite && txHit && selOk && !isStamp;

    // Per-window read data; receive and transmit reads are zero when their window is closed, filter and select reads are not gated
    wire [7:0] filtRead = filt[idx];
    // An empty queue would otherwise expose a stale frame
    wire [7:0] rxRead = receiveFullFlag ? rxHead[{~idx, 3'b000} +: 8] : 8'h00;
    wire [7:0] txRead = selOk ? txMem[txWinAddr] : 8'h00;
    wire [7:0] selRead = {5'h00, selLow};

    // Receive FIFO of whole 16-byte frames, timestamp in the last two bytes
    cfb_fifo #(
        .WIDTH(`CFB_FRAME_BITS),
        .DEPTH(`CFB_RX_STAGES),
        .AW(`CFB_RX_AW)
    ) rxQueue (
        .mclk(mclk),
        .reset_n(reset_n),
        .inValid(rxFrameValid),
        .inData(rxFrameData),
        .inReady(rxFrameReady),
        .outValid(receiveFullFlag),
        .outData(rxHead),
        .outReady(rxRelease)
    );

    always @*
    begin
        if (selLow[0])
            selIdx = 2'd0;
        else if (selLow[1])
            selIdx = 2'd1;
        else
            selIdx = 2'd2;
    end

    // Filter registers, one generate entry each
    genvar g;
    generate
        for (g = 0; g < `CFB_FILT_REGS; g = g + 1)
        begin : gFilt
            always @(posedge mclk)
            begin
                if (!reset_n)
                    filt[g] <= `CFB_FILT_RESET;
                else if (filtWriteOk && idx == g)
                    filt[g] <= cpuWdata;
            end
        end
        // Empty flag per transmit buffer; completion beats a launch in the same cycle
        for (g = 0; g < `CFB_NUM_TX; g = g + 1)
        begin : gTxFlag
            always @(posedge mclk)
            begin
                if (!reset_n)
                    txEmptyFlag[g] <= 1'b1;
                else if (txDone[g])
                    txEmptyFlag[g] <= 1'b1;
                else if (txLaunch[g])
                    txEmptyFlag[g] <= 1'b0;
            end
        end
    endgenerate

    // Select register: only changed outside initialization
    always @(posedge mclk)
    begin
        if (!reset_n)
        begin
            txBufferSelect <= `CFB_TBSEL_RESET;
            txSelectView <= `CFB_TBSEL_RESET;
        end
        else
        begin
            if (selWriteOk)
                txBufferSelect <= cpuWdata[2:0];
            txSelectView <= selLow;
        end
    end

    // Transmit buffer storage: three buffers, host writes only through the window
    integer b;
    always @(posedge mclk)
    begin
        for (b = 0; b < `CFB_NUM_TX; b = b + 1)
        begin
            if (txStampWrite[b])
            begin
                txMem[b * 16 + 14] <= txStamp[15:8];
                txMem[b * 16 + 15] <= txStamp[7:0];
            end
        end
        // Timestamp bytes never take a host write
        if (txWriteOk)
            txMem[txWinAddr] <= cpuWdata;
    end

    // Host read mux; receive window writes fall through unused
    always @*
    begin
        next_rdata = 8'h00;
        if (selHit)
            next_rdata = selRead;
        else if (filtHit)
            next_rdata = filtRead;
        else if (rxHit)
            next_rdata = rxRead;
        else if (txHit)
            next_rdata = txRead;
        else
            next_rdata = 8'h00;
    end

    always @(posedge mclk)
    begin
        if (!reset_n)
        begin
            cpuRdata <= 8'h00;
            txEngData <= 8'h00;
        end
        else
        begin
            if (cpuRead)
                cpuRdata <= next_rdata;
            if (txEngAddr < `CFB_TX_BYTES)
                txEngData <= txMem[txEngAddr];
        end
    end
endmodule // cfb_filter_window

// ---- cfb_defines.vh ----
// Constants of the CAN filter and message buffer window block.
// Included by every design file of the block; definitions only.
`ifndef CFB_DEFINES_VH
`define CFB_DEFINES_VH

// Host register map: select register byte offset, window codes in cpuAddr[5:4]
`define CFB_OFS_TBSEL 6'h0a
`define CFB_WIN_FILT 2'h1
`define CFB_WIN_RX 2'h2
`define CFB_WIN_TX 2'h3

// Byte positions inside a 16-byte message buffer
`define CFB_TS_HI 4'he
`define CFB_TS_LO 4'hf

// Reset values
`define CFB_FILT_RESET 8'h00
`define CFB_TBSEL_RESET 3'h0

// Sizes
`define CFB_FILT_REGS 16
`define CFB_NUM_TX 3
`define CFB_TX_BYTES 48
`define CFB_FRAME_BITS 128
`define CFB_RX_STAGES 4
`define CFB_RX_AW 2

`endif

// ---- cfb_fifo.v ----
// Parameterised first-in first-out buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset; flags are registered.
`timescale 1ns/10ps
`include "cfb_defines.vh"

module cfb_fifo #(
    parameter WIDTH = 128,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    // Clock and reset
    input wire mclk,
    input wire reset_n,
    // Filling side
    input wire inValid,
    input wire [WIDTH-1:0] inData,
    output reg inReady,
    // Draining side
    output reg outValid,
    output wire [WIDTH-1:0] outData,
    input wire outReady
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wrPtr;
    reg [AW-1:0] rdPtr;
    reg [AW:0] count;
    reg [AW:0] next_count;
    wire push = inValid && inReady;
    wire pop = outValid && outReady;

    assign outData = mem[rdPtr];

    always @*
    begin
        next_count = count;
        if (push && !pop)
            next_count = count + {{AW{1'b0}}, 1'b1};
        else if (pop && !push)
            next_count = count - {{AW{1'b0}}, 1'b1};
    end

    always @(posedge mclk)
    begin
        if (push)
            mem[wrPtr] <= inData;
        if (!reset_n)
        begin
            wrPtr <= {AW{1'b0}};
            rdPtr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
            inReady <= 1'b0;
            outValid <= 1'b0;
        end
        else
        begin
            if (push)
                wrPtr <= (wrPtr == DEPTH - 1) ? {AW{1'b0}} : wrPtr + {{(AW-1){1'b0}}, 1'b1};
            if (pop)
                rdPtr <= (rdPtr == DEPTH - 1) ? {AW{1'b0}} : rdPtr + {{(AW-1){1'b0}}, 1'b1};
            count <= next_count;
            // Registered flags keep both handshakes glitch free
            inReady <= (next_count != DEPTH);
            outValid <= (next_count != {(AW+1){1'b0}});
        end
    end
endmodule // cfb_fifo

// ---- cfb_filter_window_sva.sv ----
// Assertions on the host port, receive count and transmit flags.
// Assumes one clock; bound to the design by port names.
`timescale 1ns/10ps
module cfb_filter_window_sva (
    // Clock, reset and host port
    input wire mclk, input wire reset_n, input wire [5:0] cpuAddr, input wire cpuRead, input wire cpuWrite,
    input wire [7:0] cpuWdata, input wire [7:0] cpuRdata, input wire initRequest, input wire initAcknowledge,
    // Receive and transmit
    input wire rxFrameValid, input wire rxFrameReady, input wire rxRelease, input wire receiveFullFlag,
    input wire [2:0] txLaunch, input wire [2:0] txDone, input wire [2:0] txEmptyFlag, input wire [2:0] txSelectView
);
    reg [2:0] rxCount;
    wire rxPush = rxFrameValid && rxFrameReady;
    wire rxPop = rxRelease && receiveFullFlag;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    always @(posedge mclk)
    begin
        if (!reset_n)
            rxCount <= 3'h0;
        else
            rxCount <= rxCount + {2'h0, rxPush} - {2'h0, rxPop};
    end
    a_filt_write_kept: assert property (cpuWrite && cpuAddr[5:4] == 2'h1 && initRequest && initAcknowledge
        ##1 !cpuWrite ##1 cpuRead && !cpuWrite && cpuAddr == $past(cpuAddr, 2) |=> cpuRdata == $past(cpuWdata, 3))
        else $error("filter byte lost");
    a_rx_empty_zero: assert property (cpuRead && cpuAddr[5:4] == 2'h2 && !receiveFullFlag |=> cpuRdata == 8'h00)
        else $error("empty rx window not zero");
    // View lags the select register by one cycle, so skip reads right after a write
    a_tx_locked_zero: assert property (cpuRead && cpuAddr[5:4] == 2'h3 && !$past(cpuWrite)
        && (txSelectView & txEmptyFlag) == 3'h0 |=> cpuRdata == 8'h00) else $error("locked tx window not zero");
    a_sel_one_hot: assert property ($onehot0(txSelectView)) else $error("select view not one-hot");
    a_rx_full_stall: assert property (rxCount == 3'h4 |-> !rxFrameReady) else $error("ready with four stored");
    a_rx_flag_count: assert property (receiveFullFlag == (rxCount != 3'h0)) else $error("full flag wrong");
    a_tx_done_sets: assert property (txDone != 3'h0 |=> (txEmptyFlag & $past(txDone)) == $past(txDone))
        else $error("done did not set empty");
    a_tx_launch_clears: assert property ((txLaunch & ~txDone) != 3'h0
        |=> (txEmptyFlag & $past(txLaunch) & ~$past(txDone)) == 3'h0) else $error("launch did not clear empty");
    c_rx_full: cover property (rxCount == 3'h4);
    c_rx_pop: cover property (rxPop);
    c_tx_open: cover property (cpuRead && cpuAddr[5:4] == 2'h3 && (txSelectView & txEmptyFlag) != 3'h0);
endmodule // cfb_filter_window_sva
bind cfb_filter_window cfb_filter_window_sva u_sva (.*);

// ---- cfb_engine_model.sv ----
// Behavioural protocol engine: offers received frames and sends launched buffers.
// Assumes the design's clock; frames are offered by the bench through offer().
`timescale 1ns/10ps
module cfb_engine_model (
    input wire mclk, input wire rxFrameReady, input wire [2:0] txLaunch, input wire [7:0] txEngData,
    output reg rxFrameValid, output reg [127:0] rxFrameData, output reg [2:0] txDone, output reg [2:0] txStampWrite,
    output reg [15:0] txStamp, output reg [1:0] txEngBuffer, output reg [3:0] txEngIndex, output reg [7:0] lastByte
);
    initial
    begin
        {rxFrameValid, rxFrameData, txDone, txStampWrite, txStamp, txEngBuffer, txEngIndex, lastByte} = 0;
        forever
        begin
            @(posedge mclk);
            if (txLaunch != 3'h0)
            begin
                txEngBuffer <= txLaunch[0] ? 2'h0 : (txLaunch[1] ? 2'h1 : 2'h2);
                txEngIndex <= 4'h1;
                @(posedge mclk);
                @(posedge mclk) lastByte <= txEngData;
                // Slower for higher buffers
                repeat (2 + txEngBuffer) @(posedge mclk);
                txDone <= 3'h1 << txEngBuffer;
                txStampWrite <= 3'h1 << txEngBuffer;
                txStamp <= {8'h5a, lastByte};
                @(posedge mclk) {txDone, txStampWrite} <= 6'h00;
                txStamp <= ~txStamp;
            end
        end
    end
    // Valid held until taken; data inverted once released
    task offer(input [127:0] d);
    begin
        @(posedge mclk) rxFrameValid <= 1'b1;
        rxFrameData <= d;
        do @(posedge mclk); while (rxFrameReady !== 1'b1);
        rxFrameValid <= 1'b0;
        rxFrameData <= ~d;
    end
    endtask
endmodule // cfb_engine_model

// ---- tb_cfb_filter_window.sv ----
// Self-checking bench for the filter registers and buffer windows.
// Assumes the engine model on the far side and the bound checker.
`timescale 1ns/10ps
module tb_cfb_filter_window;
    reg mclk, reset_n, cpuRead, cpuWrite, initRequest, initAcknowledge, rxRelease;
    reg [5:0] cpuAddr;
    reg [7:0] cpuWdata;
    reg [2:0] txLaunch;
    wire rxFrameValid, rxFrameReady, receiveFullFlag;
    wire [127:0] rxFrameData;
    wire [2:0] txDone, txStampWrite, txEmptyFlag, txSelectView;
    wire [15:0] txStamp;
    wire [1:0] txEngBuffer;
    wire [3:0] txEngIndex;
    wire [7:0] cpuRdata, txEngData, lastByte;
    integer error_cnt, num_checks, seed, i, k;
    reg [7:0] fv [0:15];
    reg [127:0] fr [0:4];
    reg [7:0] tv [0:2];
    cfb_filter_window DUT (.*);
    cfb_engine_model ENG (.*);
    function [7:0] rxByte(input [127:0] f, input [3:0] n);
        rxByte = f[127 - 8 * n -: 8];
    endfunction
    task chk(input [7:0] got, input [7:0] exp);
    begin
        num_checks = num_checks + 1;
        if (got !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task acc(input r, input [5:0] a, input [7:0] d);
    begin
        @(posedge mclk) {cpuRead, cpuWrite} <= {r, !r};
        cpuAddr <= a;
        cpuWdata <= d;
        @(posedge mclk) {cpuRead, cpuWrite} <= 2'b00;
        #1;
        if (r)
            chk(cpuRdata, d);
    end
    endtask
    task pulse(input rel, input [2:0] l);
    begin
        @(posedge mclk) rxRelease <= rel;
        txLaunch <= l;
        @(posedge mclk) rxRelease <= 1'b0;
        txLaunch <= 3'h0;
    end
    endtask
    task print_verdict;
    begin
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
    endtask
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    initial
    begin
        #200000 error_cnt = error_cnt + 1;
        print_verdict;
    end
    initial
    begin
        {reset_n, cpuRead, cpuWrite, initRequest, initAcknowledge, rxRelease, cpuAddr, cpuWdata, txLaunch} = 0;
        error_cnt = 0;
        num_checks = 0;
        seed = 32'h8074ae69;
        repeat (8) @(posedge mclk);
        reset_n <= 1'b1;
        for (i = 0; i < 16; i = i + 1)
        begin
            fv[i] = $random(seed);
            acc(1, 6'h10 + i[5:0], 8'h00);
            acc(0, 6'h10 + i[5:0], fv[i]);
            acc(1, 6'h10 + i[5:0], 8'h00);
        end
        for (k = 0; k < 2; k = k + 1)
        begin
            @(posedge mclk) {initRequest, initAcknowledge} <= {1'b1, k == 0};
            for (i = 0; i < 16; i = i + 1)
            begin
                acc(0, 6'h10 + i[5:0], k ? ~fv[i] : fv[i]);
                acc(1, 6'h10 + i[5:0], fv[i]);
            end
        end
        @(posedge mclk) {initRequest, initAcknowledge} <= 2'b00;
        $display("filter test done");
        for (i = 0; i < 5; i = i + 1)
            fr[i] = {$random(seed), $random(seed), $random(seed), $random(seed)};
        fork
            for (k = 0; k < 5; k = k + 1)
                ENG.offer(fr[k]);
        join_none
        repeat (20) @(posedge mclk);
        for (i = 0; i < 5; i = i + 1)
        begin
            acc(1, 6'h20 + i[5:0] * 3, rxByte(fr[i], i[3:0] * 3));
            acc(1, 6'h2e, rxByte(fr[i], 4'he));
            acc(0, 6'h20, ~rxByte(fr[i], 4'h0));
            acc(1, 6'h20, rxByte(fr[i], 4'h0));
            pulse(1'b1, 3'h0);
        end
        acc(1, 6'h20, 8'h00);
        $display("receive test done");
        for (i = 0; i < 3; i = i + 1)
        begin
            tv[i] = $random(seed);
            acc(0, 6'h0a, {5'h00, 3'h7 << i});
            acc(1, 6'h0a, {5'h00, 3'h1 << i});
            acc(0, 6'h31, tv[i]);
        end
        acc(0, 6'h0a, 8'h00);
        acc(0, 6'h31, 8'h77);
        acc(1, 6'h31, 8'h00);
        for (i = 0; i < 3; i = i + 1)
        begin
            acc(0, 6'h0a, {5'h00, 3'h1 << i});
            acc(1, 6'h31, tv[i]);
            pulse(1'b0, 3'h1 << i);
            acc(1, 6'h31, 8'h00);
            for (k = 0; k < 50 && txEmptyFlag[i] !== 1'b1; k = k + 1)
                @(posedge mclk);
            chk(lastByte, tv[i]);
            acc(0, 6'h3e, 8'ha5);
            acc(1, 6'h3e, 8'h5a);
            acc(1, 6'h3f, tv[i]);
        end
        $display("transmit test done");
        print_verdict;
    end
endmodule // tb_cfb_filter_window
